// File: hdl/frg_ramp.sv
// Frequency ramp generator with APB registers, manual and automatic modes.
`timescale 1ns/100ps
module frg_ramp
  import frg_pkg::*;
#(
  parameter int unsigned AW = 8 // APB address width.
) (
  input  wire logic          pclk,              // Phase-detector clock.
  input  wire logic          presetn,           // Async reset, active low.
  input  wire logic          ce,                // Clock enable.
  input  wire logic          psel,              // APB select.
  input  wire logic          penable,           // APB enable.
  input  wire logic          pwrite,            // APB direction.
  input  wire logic [AW-1:0] paddr,             // APB byte address.
  input  wire logic [31:0]   pwdata,            // APB write data.
  output logic      [31:0]   prdata,            // APB read data.
  output logic               pready,            // APB ready.
  output logic               pslverr,           // APB error.
  input  wire logic          step_strobe_pin,   // Step strobe pin.
  input  wire logic          step_direction_pin,// Step direction pin.
  input  wire logic          cal_done,          // Calibrator finished.
  output logic               cal_start,         // Calibration start pulse.
  output logic               cal_busy,          // Calibration pause active.
  output logic      [31:0]   frac_word          // Fractional setting.
);

  // Refuse an address bus too narrow for the register map.
  if (AW < 6) begin : g_aw_check
    $error("frg_ramp: AW must be at least 6");
  end

  logic [31:0]            ctrl_r;
  logic [31:0]            start_r;
  logic [FRG_STEP_W-1:0]  step_a_r;
  logic [FRG_STEP_W-1:0]  step_b_r;
  logic [31:0]            lim_hi_r;
  logic [31:0]            lim_lo_r;
  logic [31:0]            recal_r;
  logic [FRG_LEN_W-1:0]   len_a_r;
  logic [FRG_LEN_W-1:0]   len_b_r;
  logic [31:0]            pause_r;
  frg_state_t             state_r;
  frg_state_t             state_nxt;
  logic [FRG_OFS_W-1:0]   offset_r;
  logic [FRG_OFS_W-1:0]   offset_nxt;
  logic [FRG_OFS_W-1:0]   dist_r;
  logic [FRG_LEN_W-1:0]   count_r;
  logic                   prof_r;
  logic                   phase_r;
  logic [FRG_PAUSE_W-1:0] pause_cnt_r;
  logic                   cal_seen_r;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic                   cal_start_r;
  logic                   cal_busy_r;
  logic [31:0]            frac_word_r;
  logic                   strobe_rise;
  logic                   dir_lvl;
  logic                   sweep_on;
  logic                   pin_mode;
  logic                   manual;
  logic                   auto_mode;
  logic                   cur_half;
  logic                   cur_succ;
  logic [1:0]             cur_adv;
  logic [FRG_LEN_W-1:0]   cur_len;
  logic                   strobe_src;
  logic                   man_fire;
  logic                   auto_fire;
  logic                   step_fire;
  logic                   prof_done;
  logic                   advance_now;
  logic                   recal_hit;
  logic [FRG_STEP_W-1:0]  step_val;
  logic [FRG_STEP_W-1:0]  step_mag;
  logic [FRG_OFS_W:0]     sum_ext;
  logic [FRG_OFS_W:0]     hi_ext;
  logic [FRG_OFS_W:0]     lo_ext;
  logic [FRG_OFS_W-1:0]   dist_sum;
  logic [FRG_PAUSE_W-1:0] pause_load;
  logic [3:0]             pause_shift;
  logic                   apb_access;
  logic                   apb_wr;
  logic                   rd_hit;
  logic [31:0]            rd_val;

  // Pin synchroniser; pins are asynchronous to the clock.
  frg_pin_sync u_pin_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .strobe_pin  (step_strobe_pin),
    .dir_pin     (step_direction_pin),
    .strobe_rise (strobe_rise),
    .dir_lvl     (dir_lvl)
  );

  // Mode decode and the fields of the profile now running.
  assign sweep_on  = ctrl_r[FRG_CTL_SWEEP];
  assign pin_mode  = ctrl_r[FRG_CTL_PIN];
  assign manual    = sweep_on & pin_mode;
  assign auto_mode = sweep_on & ~pin_mode;
  assign cur_half  = prof_r ? ctrl_r[FRG_CTL_HALF_B] : ctrl_r[FRG_CTL_HALF_A];
  assign cur_succ  = prof_r ? ctrl_r[FRG_CTL_SUCC_B] : ctrl_r[FRG_CTL_SUCC_A];
  assign cur_adv   = prof_r ? ctrl_r[FRG_CTL_ADV_B +: FRG_TRG_W]
                            : ctrl_r[FRG_CTL_ADV_A +: FRG_TRG_W];
  assign cur_len   = prof_r ? len_b_r : len_a_r;

  // Strobe edges pace the ramp only when a trigger source selects them.
  assign strobe_src = (ctrl_r[FRG_CTL_TRG_A +: FRG_TRG_W] == FRG_TRG_STROBE)
                    | (ctrl_r[FRG_CTL_TRG_B +: FRG_TRG_W] == FRG_TRG_STROBE);

  // Step requests; no step can fire outside RUN, so calibration drops edges.
  assign man_fire  = (state_r == FRG_RUN) & manual & strobe_rise
                   & strobe_src;
  assign auto_fire = (state_r == FRG_RUN) & auto_mode & (count_r < cur_len)
                   & (~cur_half | phase_r);
  assign step_fire = man_fire | auto_fire;

  // Step value: in manual mode direction picks B when high, A when low; otherwise the profile picks.
  assign step_val = manual ? (dir_lvl ? step_b_r : step_a_r)
                           : (prof_r ? step_b_r : step_a_r);
  assign step_mag = step_val[FRG_STEP_W-1] ? (~step_val + 30'h1) : step_val;

  // Signed sum with ceiling and floor in the offset's own encoding.
  assign sum_ext = {offset_r[FRG_OFS_W-1], offset_r}
                 + {{(FRG_OFS_W+1-FRG_STEP_W){step_val[FRG_STEP_W-1]}},
                    step_val};
  assign hi_ext  = {2'b00, lim_hi_r};
  assign lo_ext  = {2'b11, lim_lo_r};

  // Next offset, clamped to the limits.
  always_comb begin
    if ($signed(sum_ext) > $signed(hi_ext)) begin
      offset_nxt = hi_ext[FRG_OFS_W-1:0];
    end else if ($signed(sum_ext) < $signed(lo_ext)) begin
      offset_nxt = lo_ext[FRG_OFS_W-1:0];
    end else begin
      offset_nxt = sum_ext[FRG_OFS_W-1:0];
    end
  end

  // Distance since the last calibration and the threshold check.
  assign dist_sum  = dist_r + {3'b000, step_mag};
  assign recal_hit = step_fire & (dist_sum > {1'b0, recal_r});

  // Profile end and the move to its successor.
  assign prof_done   = (state_r == FRG_RUN) & auto_mode & (count_r >= cur_len);
  assign advance_now = (prof_done & (cur_adv == FRG_TRG_TIMEOUT))
                     | ((state_r == FRG_WAIT) & strobe_rise);

  // Pause length in clock cycles: base shifted by scale plus divider.
  assign pause_shift = {1'b0, pause_r[FRG_PS_SCALE +: FRG_SCALE_W]}
                     + {2'b00, pause_r[FRG_PS_DIV +: FRG_DIV_W]};
  assign pause_load  = {{(FRG_PAUSE_W-FRG_BASE_W){1'b0}},
                        pause_r[FRG_PS_BASE +: FRG_BASE_W]} << pause_shift;

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FRG_IDLE: begin
        if (sweep_on) begin
          state_nxt = FRG_RUN;
        end
      end
      FRG_RUN: begin
        if (!sweep_on) begin
          state_nxt = FRG_IDLE;
        end else if (recal_hit) begin
          state_nxt = FRG_CAL;
        end else if (prof_done && cur_adv != FRG_TRG_TIMEOUT) begin
          state_nxt = FRG_WAIT;
        end
      end
      FRG_WAIT: begin
        if (!sweep_on) begin
          state_nxt = FRG_IDLE;
        end else if (strobe_rise || pin_mode) begin
          state_nxt = FRG_RUN;
        end
      end
      FRG_CAL: begin
        if (!sweep_on) begin
          state_nxt = FRG_IDLE;
        end else if (pause_cnt_r == '0 && cal_seen_r) begin
          state_nxt = FRG_RUN;
        end
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FRG_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Ramp offset; cleared while sweeping is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_r <= '0;
    end else if (ce) begin
      if (!sweep_on) begin
        offset_r <= '0;
      end else if (step_fire) begin
        offset_r <= offset_nxt;
      end
    end
  end

  // Accumulated distance; restarts at each calibration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dist_r <= '0;
    end else if (ce) begin
      if (!sweep_on || recal_hit) begin
        dist_r <= '0;
      end else if (step_fire) begin
        dist_r <= dist_sum;
      end
    end
  end

  // Profile select, step counter and half-rate phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prof_r  <= 1'b0;
      count_r <= '0;
      phase_r <= 1'b0;
    end else if (ce) begin
      if (state_r == FRG_IDLE) begin
        prof_r  <= 1'b0;
        count_r <= '0;
        phase_r <= 1'b0;
      end else if (advance_now) begin
        prof_r  <= cur_succ;
        count_r <= '0;
        phase_r <= 1'b0;
      end else if (state_r == FRG_RUN && auto_mode && count_r < cur_len) begin
        phase_r <= cur_half & ~phase_r;
        if (auto_fire) begin
          count_r <= count_r + 17'h1;
        end
      end
    end
  end

  // Pause counter and calibrator completion flag; set wins over clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_cnt_r <= '0;
      cal_seen_r  <= 1'b0;
    end else if (ce) begin
      if (recal_hit) begin
        pause_cnt_r <= pause_load;
      end else if (state_r == FRG_CAL && pause_cnt_r != '0) begin
        pause_cnt_r <= pause_cnt_r - 27'h1;
      end
      if (cal_done) begin
        cal_seen_r <= 1'b1;
      end else if (recal_hit) begin
        cal_seen_r <= 1'b0;
      end
    end
  end

  // Calibration outputs and the fractional word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_start_r <= 1'b0;
      cal_busy_r  <= 1'b0;
      frac_word_r <= FRG_RST_WORD;
    end else if (ce) begin
      cal_start_r <= recal_hit;
      cal_busy_r  <= (state_nxt == FRG_CAL);
      frac_word_r <= start_r + offset_nxt_sel();
    end
  end

  // Offset that the word will carry after this edge.
  function automatic logic [31:0] offset_nxt_sel();
    if (!sweep_on) begin
      return 32'h0000_0000;
    end else if (step_fire) begin
      return offset_nxt[31:0];
    end else begin
      return offset_r[31:0];
    end
  endfunction : offset_nxt_sel

  // APB read multiplexer with unmapped-address detection.
  always_comb begin
    rd_hit = (paddr[1:0] == 2'b00);
    rd_val = 32'h0000_0000;
    unique case (8'(paddr))
      FRG_ADDR_CTRL:   rd_val = ctrl_r;
      FRG_ADDR_START:  rd_val = start_r;
      FRG_ADDR_STEP_A: rd_val = {2'b00, step_a_r};
      FRG_ADDR_STEP_B: rd_val = {2'b00, step_b_r};
      FRG_ADDR_LIM_HI: rd_val = lim_hi_r;
      FRG_ADDR_LIM_LO: rd_val = lim_lo_r;
      FRG_ADDR_RECAL:  rd_val = recal_r;
      FRG_ADDR_LEN_A:  rd_val = {15'h0000, len_a_r};
      FRG_ADDR_LEN_B:  rd_val = {15'h0000, len_b_r};
      FRG_ADDR_PAUSE:  rd_val = pause_r;
      FRG_ADDR_STATUS: begin
        rd_val[FRG_ST_CAL]  = (state_r == FRG_CAL);
        rd_val[FRG_ST_PROF] = prof_r;
        rd_val[FRG_ST_WAIT] = (state_r == FRG_WAIT);
        rd_val[FRG_ST_RUN]  = (state_r == FRG_RUN);
      end
      FRG_ADDR_FREQ:   rd_val = frac_word_r;
      default:         rd_hit = 1'b0;
    endcase
    if (AW'(8'(paddr)) != paddr) begin // Upper address bits must be zero.
      rd_hit = 1'b0;
    end
  end

  // One wait state: ready rises in the second access cycle.
  assign apb_access = psel & penable;
  assign apb_wr     = apb_access & pready_r & pwrite & rd_hit;

  // APB response registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= FRG_RST_WORD;
    end else if (ce) begin
      pready_r  <= apb_access & ~pready_r;
      pslverr_r <= apb_access & ~pready_r & ~rd_hit;
      if (apb_access && !pready_r && !pwrite) begin
        prdata_r <= rd_hit ? rd_val : FRG_RST_WORD;
      end
    end
  end

  // Writable registers; status and frequency words are read-only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= FRG_RST_WORD;
      start_r  <= FRG_RST_WORD;
      step_a_r <= '0;
      step_b_r <= '0;
      lim_hi_r <= FRG_RST_WORD;
      lim_lo_r <= FRG_RST_WORD;
      recal_r  <= FRG_RST_WORD;
      len_a_r  <= '0;
      len_b_r  <= '0;
      pause_r  <= FRG_RST_WORD;
    end else if (ce && apb_wr) begin
      unique case (8'(paddr))
        FRG_ADDR_CTRL:   ctrl_r   <= pwdata;
        FRG_ADDR_START:  start_r  <= pwdata;
        FRG_ADDR_STEP_A: step_a_r <= pwdata[FRG_STEP_W-1:0];
        FRG_ADDR_STEP_B: step_b_r <= pwdata[FRG_STEP_W-1:0];
        FRG_ADDR_LIM_HI: lim_hi_r <= pwdata;
        FRG_ADDR_LIM_LO: lim_lo_r <= pwdata;
        FRG_ADDR_RECAL:  recal_r  <= pwdata;
        FRG_ADDR_LEN_A:  len_a_r  <= (pwdata[FRG_LEN_W-1:0] > FRG_LEN_MAX)
                                     ? FRG_LEN_MAX : pwdata[FRG_LEN_W-1:0];
        FRG_ADDR_LEN_B:  len_b_r  <= (pwdata[FRG_LEN_W-1:0] > FRG_LEN_MAX)
                                     ? FRG_LEN_MAX : pwdata[FRG_LEN_W-1:0];
        FRG_ADDR_PAUSE:  pause_r  <= pwdata;
        default: ;
      endcase
    end
  end

  // Outputs straight from flip-flops.
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign cal_start = cal_start_r;
  assign cal_busy  = cal_busy_r;
  assign frac_word = frac_word_r;

  // Checks on the ramp behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_pause3;
    cal_busy_r [*3];
  endsequence

  sequence s_new_prof(logic succ);
    prof_r == succ && count_r == '0;
  endsequence

  a_manual_gate: assert property (man_fire |-> sweep_on && pin_mode)
    else $error("manual step outside manual mode");
  a_strobe_only: assert property (ce && manual && state_r == FRG_RUN
    && !strobe_rise |=> $stable(offset_r))
    else $error("manual step without strobe edge");
  a_dir_pick: assert property (man_fire && ce |-> step_val ==
    (dir_lvl ? step_b_r : step_a_r))
    else $error("wrong step size for direction");
  a_cal_drop: assert property (ce && strobe_rise && state_r == FRG_CAL
    |=> $stable(offset_r))
    else $error("strobe edge stepped during calibration");
  a_ceiling_hold: assert property (ce && step_fire && sweep_on |=>
    $signed(offset_r) <= $signed({1'b0, $past(lim_hi_r)}))
    else $error("offset above ceiling");
  a_floor_hold: assert property (ce && step_fire && sweep_on |=>
    $signed({offset_r[FRG_OFS_W-1], offset_r}) >=
    $signed({2'b11, $past(lim_lo_r)}))
    else $error("offset below floor");
  a_recal_start: assert property (ce && recal_hit |=> cal_start_r
    && cal_busy_r && dist_r == '0)
    else $error("threshold did not start calibration");
  a_auto_mode: assert property (auto_fire |-> sweep_on && !pin_mode)
    else $error("automatic step outside automatic mode");
  a_auto_rate: assert property (ce && state_r == FRG_RUN && auto_mode
    && count_r < cur_len && !cur_half |-> auto_fire)
    else $error("automatic mode missed a cycle");
  a_cal_freeze: assert property (cal_busy_r |-> !step_fire)
    else $error("step during calibration pause");
  a_half_rate: assert property (ce && auto_fire && cur_half |=>
    !auto_fire)
    else $error("half-rate profile stepped twice in a row");
  a_len_bound: assert property (ce && auto_fire |=> count_r <= cur_len
    && count_r == $past(count_r) + 17'h1)
    else $error("step count overran profile length");
  a_next_prof: assert property (ce && prof_done && cur_adv == FRG_TRG_TIMEOUT
    |=> s_new_prof($past(cur_succ)))
    else $error("profile did not advance to successor");
  a_pause_min: assert property (cal_start_r && pause_cnt_r >= 27'h2
    |-> s_pause3)
    else $error("calibration pause too short");
  a_sweep_off: assert property (ce && !sweep_on |=> offset_r == '0
    && frac_word_r == $past(start_r))
    else $error("offset held while sweeping off");

endmodule : frg_ramp

// File: hdl/frg_pkg.sv
// Package with register map, field layout and types of the frequency ramp generator.
package frg_pkg;

  // Register byte offsets on the APB register bus.
  localparam logic [7:0] FRG_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] FRG_ADDR_START  = 8'h04;
  localparam logic [7:0] FRG_ADDR_STEP_A = 8'h08;
  localparam logic [7:0] FRG_ADDR_STEP_B = 8'h0C;
  localparam logic [7:0] FRG_ADDR_LIM_HI = 8'h10;
  localparam logic [7:0] FRG_ADDR_LIM_LO = 8'h14;
  localparam logic [7:0] FRG_ADDR_RECAL  = 8'h18;
  localparam logic [7:0] FRG_ADDR_LEN_A  = 8'h1C;
  localparam logic [7:0] FRG_ADDR_LEN_B  = 8'h20;
  localparam logic [7:0] FRG_ADDR_PAUSE  = 8'h24;
  localparam logic [7:0] FRG_ADDR_STATUS = 8'h28;
  localparam logic [7:0] FRG_ADDR_FREQ   = 8'h2C;

  // Control register bit positions.
  localparam int unsigned FRG_CTL_SWEEP  = 0;
  localparam int unsigned FRG_CTL_PIN    = 1;
  localparam int unsigned FRG_CTL_HALF_A = 2;
  localparam int unsigned FRG_CTL_HALF_B = 3;
  localparam int unsigned FRG_CTL_SUCC_A = 4;
  localparam int unsigned FRG_CTL_SUCC_B = 5;
  localparam int unsigned FRG_CTL_TRG_A  = 8;
  localparam int unsigned FRG_CTL_TRG_B  = 10;
  localparam int unsigned FRG_CTL_ADV_A  = 12;
  localparam int unsigned FRG_CTL_ADV_B  = 14;

  // Pause register field positions.
  localparam int unsigned FRG_PS_BASE  = 0;
  localparam int unsigned FRG_PS_SCALE = 16;
  localparam int unsigned FRG_PS_DIV   = 20;

  // Status register bit positions.
  localparam int unsigned FRG_ST_CAL  = 0;
  localparam int unsigned FRG_ST_PROF = 1;
  localparam int unsigned FRG_ST_WAIT = 2;
  localparam int unsigned FRG_ST_RUN  = 3;

  // Field widths.
  localparam int unsigned FRG_TRG_W   = 2;
  localparam int unsigned FRG_STEP_W  = 30;
  localparam int unsigned FRG_OFS_W   = 33;
  localparam int unsigned FRG_LEN_W   = 17;
  localparam int unsigned FRG_BASE_W  = 16;
  localparam int unsigned FRG_SCALE_W = 3;
  localparam int unsigned FRG_DIV_W   = 2;
  localparam int unsigned FRG_PAUSE_W = 27;

  // Trigger source codes.
  localparam logic [1:0] FRG_TRG_TIMEOUT = 2'h0;
  localparam logic [1:0] FRG_TRG_STROBE  = 2'h1;

  // Reset value and profile length limit.
  localparam logic [31:0] FRG_RST_WORD = 32'h0000_0000;
  localparam logic [16:0] FRG_LEN_MAX  = 17'h1_0000;

  // Sequencer states.
  typedef enum logic [1:0] {
    FRG_IDLE,
    FRG_RUN,
    FRG_WAIT,
    FRG_CAL
  } frg_state_t;

endpackage : frg_pkg

// File: hdl/frg_pin_sync.sv
// Synchroniser and rising-edge detector for the strobe and direction pins.
`timescale 1ns/100ps
module frg_pin_sync (
  input  wire logic pclk,        // Phase-detector clock.
  input  wire logic presetn,     // Asynchronous reset, active low.
  input  wire logic ce,          // Clock enable.
  input  wire logic strobe_pin,  // Raw step strobe pin.
  input  wire logic dir_pin,     // Raw step direction pin.
  output logic      strobe_rise, // One-cycle pulse on strobe rising edge.
  output logic      dir_lvl      // Direction aligned with strobe_rise.
);

  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic       strobe_old_r;

  // Two flip-flops per pin; only the second stage feeds any logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r       <= 2'h0;
      sync_r       <= 2'h0;
      strobe_old_r <= 1'b0;
    end else if (ce) begin
      meta_r       <= {dir_pin, strobe_pin};
      sync_r       <= meta_r;
      strobe_old_r <= sync_r[0];
    end
  end

  // Edge and direction come from the same stage so they stay aligned.
  assign strobe_rise = sync_r[0] & ~strobe_old_r;
  assign dir_lvl     = sync_r[1];

endmodule : frg_pin_sync

// File: verification/frg_host_model.sv
// Host controller model that pulses the step strobe and direction pins.
`timescale 1ns/100ps
module frg_host_model #(
  parameter int HALF = 400 // One less than the cycles per strobe half period.
) (
  input  wire logic pclk,               // Clock.
  input  wire logic presetn,            // Reset, active low.
  input  wire logic go,                 // Request one strobe.
  input  wire logic dir_in,             // Wanted direction.
  output logic      step_strobe_pin,    // Strobe pin.
  output logic      step_direction_pin, // Direction pin.
  output logic      busy                // Strobe in progress.
);
  logic [1:0]  ph_r;
  logic [15:0] cnt_r;

  // Direction settles while low, then one slow high and low half period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ph_r, cnt_r, step_strobe_pin, step_direction_pin} <= '0;
    end else if (ph_r == 2'd0) begin
      if (go) begin
        {ph_r, cnt_r, step_direction_pin} <= {2'd1, 16'(HALF), dir_in};
      end
    end else if (cnt_r != 16'd0) begin
      cnt_r <= cnt_r - 16'd1;
    end else if (ph_r != 2'd3) begin
      {ph_r, cnt_r, step_strobe_pin} <= {ph_r + 2'd1, 16'(HALF), ph_r == 2'd1};
    end else begin
      ph_r <= 2'd0;
    end
  end

  // The model is busy until the low half period has run out.
  assign busy = (ph_r != 2'd0);
endmodule : frg_host_model

// File: verification/frg_ramp_tb_top.sv
// Self-checking testbench of the frequency ramp generator.
`timescale 1ns/100ps
module frg_ramp_tb_top;
  import frg_pkg::*;
  typedef struct {logic d; logic [31:0] f;} frg_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        go, dir_in, busy, cal_done, cal_start, cal_busy, stb, dir;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, frac_word, rd;
  int          err_total = 0, n_compared = 0, cyc = 0, n_cal = 0;
  frg_row_t    rows [4] = '{'{1'b1, 32'h1000_0003}, '{1'b0, 32'h0FFF_FFFE},
                            '{1'b1, 32'h1000_0001}, '{1'b1, 32'h1000_0004}};

  frg_ramp i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_strobe_pin(stb), .step_direction_pin(dir), .cal_done(cal_done),
    .cal_start(cal_start), .cal_busy(cal_busy), .frac_word(frac_word));
  frg_host_model #(.HALF(400)) i_host (.pclk(pclk), .presetn(presetn),
    .go(go), .dir_in(dir_in), .step_strobe_pin(stb),
    .step_direction_pin(dir), .busy(busy));

  // Clock generator.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Calibrator answers a cycle into each pause; starts are counted.
  always @(posedge pclk) begin
    cal_done <= cal_busy;
    cyc <= cyc + 1;
    if (cal_start === 1'b1) n_cal <= n_cal + 1;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task step(input logic d);
    @(posedge pclk);
    {go, dir_in} <= {1'b1, d};
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask : step

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Main sequence: reset, manual rows, then refusals, limits and auto mode.
  initial begin
    {presetn, psel, penable, pwrite, go, dir_in, paddr} = '0;
    pwdata = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FRG_ADDR_CTRL, 32'h0000_0000);
    chk(rd, FRG_RST_WORD);
    chk(frac_word, 32'h0000_0000);
    apb(1'b1, FRG_ADDR_START, 32'h1000_0000);
    apb(1'b1, FRG_ADDR_STEP_A, 32'h3FFF_FFFB);
    apb(1'b1, FRG_ADDR_STEP_B, 32'h0000_0003);
    apb(1'b1, FRG_ADDR_LIM_HI, 32'h0000_0010);
    apb(1'b1, FRG_ADDR_LIM_LO, 32'hFFFF_FF00);
    apb(1'b1, FRG_ADDR_RECAL, 32'h3FFF_FFFF);
    apb(1'b1, FRG_ADDR_LEN_A, 32'h0000_0004);
    step(1'b1);
    chk(frac_word, 32'h1000_0000);
    apb(1'b1, FRG_ADDR_CTRL, 32'h0000_0003);
    step(1'b1);
    chk(frac_word, 32'h1000_0000);
    apb(1'b1, FRG_ADDR_CTRL, 32'h0000_5103);
    foreach (rows[i]) begin
      step(rows[i].d);
      chk(frac_word, rows[i].f);
    end
    repeat (5) step(1'b1);
    chk(frac_word, 32'h1000_0010);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, FRG_ADDR_CTRL, 32'h0000_0001);
    repeat (600) @(posedge pclk);
    chk(frac_word, 32'h0FFF_FF00);
    // Calibration: the second strobe falls inside the 2048-cycle pause.
    apb(1'b1, FRG_ADDR_CTRL, 32'h0000_5103);
    apb(1'b1, FRG_ADDR_PAUSE, 32'h0000_0800);
    apb(1'b1, FRG_ADDR_RECAL, 32'h0000_0004);
    step(1'b1);
    chk({31'h0, cal_busy}, 32'h0000_0001);
    chk(frac_word, 32'h0FFF_FF03);
    step(1'b0);
    chk(frac_word, 32'h0FFF_FF03);
    step(1'b1);
    chk({31'h0, cal_busy}, 32'h0000_0000);
    chk(frac_word, 32'h0FFF_FF06);
    chk(n_cal, 32'h0000_0001);
    // Two profiles from a clean start: A at half rate (-5), then B (+3).
    apb(1'b1, FRG_ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, FRG_ADDR_RECAL, 32'h3FFF_FFFF);
    apb(1'b1, FRG_ADDR_LEN_B, 32'h0000_0002);
    apb(1'b1, FRG_ADDR_CTRL, 32'h0000_0015);
    repeat (13) @(posedge pclk);
    chk(frac_word, 32'h0FFF_FFF2);
    end_sim();
  end
endmodule : frg_ramp_tb_top
